// File: bench/asac_modem.sv
// modem model: serial frames into the core, captured frames out of it
`timescale 1ns/1ps
`default_nettype none
module asac_modem (
  input wire logic mclk,
  input wire logic txd,
  output var logic rxd
);
  // one bit is 16 ticks of 6 cycles at divider code f
  localparam int BT = 96;
  logic [15:0] cap = 16'h0000;
  // start bit, then n bits lsb first; the last one sent is the stop
  task automatic send(input logic [9:0] v, input int n);
    rxd <= 1'b0;
    repeat (BT) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      rxd <= v[i];
      repeat (BT) @(posedge mclk);
    end
  endtask : send
  // nine samples taken mid-bit; result only published once complete
  initial begin
    logic [15:0] t;
    rxd = 1'b1;
    forever begin
      @(negedge txd);
      t = 16'h0000;
      repeat (BT / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++) begin
        repeat (BT) @(posedge mclk);
        t[i] = txd;
      end
      cap = t;
    end
  end
endmodule : asac_modem
`default_nettype wire

// File: bench/testbench.sv
// self-checking bench for the serial core: register access and modem traffic
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic bus_sel = 1'b0;
  logic bus_rw = 1'b0;
  logic [1:0] bus_rs = 2'h0;
  logic [7:0] bus_din = 8'h00;
  logic cts_n = 1'b0;
  logic dsr_n = 1'b0;
  logic cd = 1'b0;
  logic [7:0] bus_dout;
  logic bus_doe, irq_n, rc_out, rc_oe, rxd, txd, rts_n, dtr_n;
  logic [1:0] p;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [2:0] xdiv = 3'h0;
  int rc_cnt = 0;
  int rc_base = 0;

  asac_core #(.CTS_DEFER(1'b1)) i_asac_core (
    .mclk(mclk), .rst_b(rst_b), .bus_sel(bus_sel), .bus_rw(bus_rw), .bus_rs(bus_rs),
    .bus_din(bus_din), .bus_dout(bus_dout), .bus_doe(bus_doe), .irq_n(irq_n),
    .baud_clk_in(xdiv < 3'h3), .receive_clock_pin_in(rc_oe ? rc_out : (xdiv < 3'h3)),
    .receive_clock_pin_out(rc_out), .receive_clock_pin_oe(rc_oe), .rxd(rxd), .txd(txd),
    .cts_n(cts_n), .dsr_n(dsr_n), .carrier_detect_in(cd), .rts_n(rts_n), .dtr_n(dtr_n)
  );
  asac_modem i_asac_modem (.mclk(mclk), .txd(txd), .rxd(rxd));

  // 25 MHz
  always #20 mclk = ~mclk;

  // external 16x clock, one rising edge per six cycles like divider code f
  always @(posedge mclk) begin
    xdiv <= (xdiv == 3'h5) ? 3'h0 : xdiv + 3'h1;
  end

  // 16x pulses seen while the core drives its clock pin
  always @(posedge mclk) begin
    if (rc_oe && rc_out) begin
      rc_cnt++;
    end
  end

  task automatic final_report();
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // hang guard, well above the roughly 32k cycles the run needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chb(input string n, input logic e, input logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask : chb

  // wait, then step off the edge so outputs have settled
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : w

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_sel <= 1'b1;
    bus_rw <= 1'b0;
    bus_rs <= a;
    bus_din <= d;
    @(posedge mclk);
    bus_sel <= 1'b0;
  endtask : wr

  // read strobe, then data sampled in the single cycle it is flagged
  task automatic rk(input string n, input logic [1:0] a, input logic [7:0] e);
    @(posedge mclk);
    bus_sel <= 1'b1;
    bus_rw <= 1'b1;
    bus_rs <= a;
    @(posedge mclk);
    bus_sel <= 1'b0;
    #1;
    chb("bus_doe", 1'b1, bus_doe);
    chk(n, {8'h00, e}, {8'h00, bus_dout});
  endtask : rk

  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    w(3);
    chb("dtr_n", 1'b1, dtr_n);
    rk("status", 2'h1, 8'h70);
    wr(2'h3, 8'h1f);
    wr(2'h2, 8'h05);
    w(2);
    chb("rc_oe", 1'b1, rc_oe);
    chb("dtr_n", 1'b0, dtr_n);
    chb("rts_n", 1'b0, rts_n);
    // one 16x pulse on the clock pin every six cycles
    rc_base = rc_cnt;
    w(60);
    chk("rc pulses", 16'h000a, 16'(rc_cnt - rc_base));
    // empty interrupt at start bit, mark when not reloaded
    for (int k = 0; k < 2; k++) begin
      wr(2'h0, k == 0 ? 8'ha5 : 8'h3c);
      w(4);
      chb("irq_n", 1'b0, irq_n);
      rk("status", 2'h1, 8'hf0);
      chb("irq_n", 1'b1, irq_n);
      w(1200);
      chk("frame", k == 0 ? 16'h01a5 : 16'h013c, i_asac_modem.cap);
      chb("txd", 1'b1, txd);
    end
    // pass through 00 on the way from 01 to 10
    wr(2'h2, 8'h01);
    w(2);
    chb("rts_n", 1'b1, rts_n);
    wr(2'h2, 8'h09);
    // seven bits with each parity type
    wr(2'h3, 8'h3f);
    for (int k = 0; k < 4; k++) begin
      p = 2'(k);
      wr(2'h2, {p, 6'h29});
      wr(2'h0, 8'h55);
      w(1200);
      chk("parity frame", {7'h00, 1'b1, ~p[0], 7'h55}, i_asac_modem.cap);
    end
    wr(2'h3, 8'h1f);
    wr(2'h2, 8'h09);
    // receive full flagged and data unpacked
    i_asac_modem.send({1'b1, 8'h3c}, 9);
    w(10);
    chb("irq_n", 1'b0, irq_n);
    rk("status", 2'h1, 8'hf8);
    rk("rx data", 2'h0, 8'h3c);
    rk("status", 2'h1, 8'h70);
    // external transmit clock, then receiver clocked from the pin
    wr(2'h3, 8'h10);
    wr(2'h0, 8'h5e);
    w(1200);
    chk("ext frame", 16'h015e, i_asac_modem.cap);
    wr(2'h3, 8'h0f);
    i_asac_modem.send({1'b1, 8'ha7}, 9);
    w(10);
    rk("rx data", 2'h0, 8'ha7);
    rk("status", 2'h1, 8'hf0);
    wr(2'h3, 8'h1f);
    // carrier loss held until read, then rechecked
    @(posedge mclk);
    cd <= 1'b1;
    w(10);
    chb("irq_n", 1'b0, irq_n);
    @(posedge mclk);
    cd <= 1'b0;
    w(10);
    rk("status", 2'h1, 8'hd0);
    w(10);
    chb("irq_n", 1'b0, irq_n);
    rk("status", 2'h1, 8'hf0);
    chb("irq_n", 1'b1, irq_n);
    wr(2'h2, 8'h11);
    w(2);
    chb("rts_n", 1'b0, rts_n);
    i_asac_modem.send({1'b1, 8'h96}, 9);
    w(150);
    chk("echo frame", 16'h0196, i_asac_modem.cap);
    rk("rx data", 2'h0, 8'h96);
    rk("status", 2'h1, 8'hf0);
    // deferred clear-to-send finishes the character, holds mark, resumes
    wr(2'h2, 8'h09);
    wr(2'h0, 8'h33);
    w(100);
    @(posedge mclk);
    cts_n <= 1'b1;
    w(1100);
    chk("frame", 16'h0133, i_asac_modem.cap);
    wr(2'h0, 8'h44);
    w(300);
    chb("txd", 1'b1, txd);
    @(posedge mclk);
    cts_n <= 1'b0;
    w(1200);
    chk("frame", 16'h0144, i_asac_modem.cap);
    // overrun without interrupt, first word kept
    wr(2'h2, 8'h0b);
    for (int k = 0; k < 18; k++) begin
      i_asac_modem.send({1'b1, 8'(8'h40 + k)}, 9);
    end
    w(10);
    chb("irq_n", 1'b1, irq_n);
    rk("status", 2'h1, 8'h7c);
    rk("rx data", 2'h0, 8'h40);
    // break only once empty, then a stop bit
    wr(2'h2, 8'h0d);
    w(20);
    chb("txd", 1'b0, txd);
    wr(2'h2, 8'h09);
    w(200);
    chb("txd", 1'b1, txd);
    // program reset clears low command bits and overrun, not high command bits or control
    wr(2'h2, 8'he9);
    wr(2'h1, 8'h5a);
    w(2);
    rk("command", 2'h2, 8'he0);
    rk("control", 2'h3, 8'h1f);
    chb("dtr_n", 1'b1, dtr_n);
    final_report();
  end
endmodule : testbench
`default_nettype wire

// File: rtl/asac_cfg.svh
// register selects, field positions, reset values and tick counts of the serial core
`ifndef ASAC_CFG_SVH
`define ASAC_CFG_SVH
`define ASAC_RS_DATA 2'h0
`define ASAC_RS_STAT 2'h1
`define ASAC_RS_CMD 2'h2
`define ASAC_RS_CTRL 2'h3
`define ASAC_CMD_RST 8'h00
`define ASAC_CTRL_RST 8'h00
`define ASAC_RATE_EXT 4'h0
`define ASAC_B_RXSRC 4
`define ASAC_B_STOP 7
`define ASAC_B_ECHO 4
`define ASAC_B_PAREN 5
`define ASAC_TXI_OFF 2'h0
`define ASAC_TXI_ON 2'h1
`define ASAC_TXI_BRK 2'h3
`define ASAC_PAR_ODD 2'h0
`define ASAC_PAR_EVEN 2'h1
`define ASAC_PAR_MARK 2'h2
`define ASAC_TICK_MID 5'h07
`define ASAC_TICK_END 5'h0f
`define ASAC_TICK_TAIL 5'h0b
`define ASAC_STOP1 5'h0f
`define ASAC_STOP15 5'h17
`define ASAC_STOP2 5'h1f
`define ASAC_FIFO_W 10
`define ASAC_FIFO_D 16
`endif

// File: rtl/asac_core.sv
// serial adapter core: registers, baud timing, transmitter, receiver, modem lines
`timescale 1ns/1ps
`default_nettype none
`include "asac_cfg.svh"
module asac_core
  import asac_pkg::*;
#(
  parameter bit CTS_DEFER = 1'b1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic bus_sel,
  input wire logic bus_rw,
  input wire logic [1:0] bus_rs,
  input wire logic [7:0] bus_din,
  output logic [7:0] bus_dout,
  output logic bus_doe,
  output logic irq_n,
  input wire logic baud_clk_in,
  input wire logic receive_clock_pin_in,
  output logic receive_clock_pin_out,
  output logic receive_clock_pin_oe,
  input wire logic rxd,
  output logic txd,
  input wire logic cts_n,
  input wire logic dsr_n,
  input wire logic carrier_detect_in,
  output logic rts_n,
  output logic dtr_n
);
  asac_state_s st_q, st_d;
  logic rd, wr, tick_t, tick_r, echo_on, cts_hi;
  logic ev_rx, ev_tx, ev_mdm, ev_any;
  logic push, push_v, push_rdy, pop_v, pop_rdy;
  logic [9:0] push_w, pop_w;
  logic [3:0] nb;
  logic [4:0] stop_end;

  // reload value of the 16x tick counter
  function automatic logic [11:0] f_div(input logic [3:0] r);
    logic [15:0] v;
    case (r)
      4'h1: v = 16'h9000;
      4'h2: v = 16'h6000;
      4'h3: v = 16'h4180;
      4'h4: v = 16'h3580;
      4'h5: v = 16'h3000;
      4'h6: v = 16'h1800;
      4'h7: v = 16'h0c00;
      4'h8: v = 16'h0600;
      4'h9: v = 16'h0400;
      4'ha: v = 16'h0300;
      4'hb: v = 16'h0200;
      4'hc: v = 16'h0180;
      4'hd: v = 16'h0100;
      4'he: v = 16'h00c0;
      default: v = 16'h0060;
    endcase
    f_div = v[15:4] - 12'h001;
  endfunction : f_div

  function automatic logic [3:0] f_nbits(input logic [7:0] c);
    f_nbits = 4'h8 - {2'h0, c[6:5]};
  endfunction : f_nbits

  // last tick of the stop period, in 16x ticks
  function automatic logic [4:0] f_stop(input logic [7:0] c, input logic [7:0] m);
    if (!c[`ASAC_B_STOP]) begin
      f_stop = `ASAC_STOP1;
    end else if (c[6:5] == 2'h3 && !m[`ASAC_B_PAREN]) begin
      f_stop = `ASAC_STOP15;
    end else if (c[6:5] == 2'h0 && m[`ASAC_B_PAREN]) begin
      f_stop = `ASAC_STOP1;
    end else begin
      f_stop = `ASAC_STOP2;
    end
  endfunction : f_stop

  // parity bit over the used data bits only
  function automatic logic f_par(input logic [7:0] dat, input logic [3:0] n, input logic [1:0] md);
    logic [7:0] m;
    m = dat & ~(8'hff << n);
    case (md)
      `ASAC_PAR_ODD: f_par = ~(^m);
      `ASAC_PAR_EVEN: f_par = ^m;
      `ASAC_PAR_MARK: f_par = 1'b1;
      default: f_par = 1'b0;
    endcase
  endfunction : f_par

  // receive words queue here; the data register drains it when free
  asac_fifo #(
    .W(`ASAC_FIFO_W),
    .D(`ASAC_FIFO_D)
  ) u_rxq (
    .mclk(mclk),
    .rst_b(rst_b),
    .in_data(push_w),
    .in_valid(push_v),
    .in_ready(push_rdy),
    .out_data(pop_w),
    .out_valid(pop_v),
    .out_ready(pop_rdy)
  );

  always_comb begin
    st_d = st_q;
    rd = bus_sel & bus_rw;
    wr = bus_sel & ~bus_rw;
    ev_rx = 1'b0;
    ev_tx = 1'b0;
    ev_mdm = 1'b0;
    push = 1'b0;
    push_w = {st_q.rx_pe, st_q.rx_fe, st_q.rx_sh};
    // pin synchronisers, first stage feeds only the second
    st_d.s_xt = {st_q.s_xt[0], baud_clk_in};
    st_d.s_rc = {st_q.s_rc[0], receive_clock_pin_in};
    st_d.s_rx = {st_q.s_rx[0], rxd};
    st_d.s_cts = {st_q.s_cts[0], cts_n};
    st_d.s_car = {st_q.s_car[0], carrier_detect_in};
    st_d.s_dsr = {st_q.s_dsr[0], dsr_n};
    st_d.xt_old = st_q.s_xt[1];
    st_d.rc_old = st_q.s_rc[1];
    nb = f_nbits(st_q.ctrl);
    stop_end = f_stop(st_q.ctrl, st_q.cmd);
    echo_on = st_q.cmd[`ASAC_B_ECHO] & (st_q.cmd[3:2] == `ASAC_TXI_OFF);
    cts_hi = st_q.s_cts[1];

    tick_t = 1'b0;
    if (st_q.ctrl[3:0] == `ASAC_RATE_EXT) begin
      tick_t = st_q.s_xt[1] & ~st_q.xt_old;
      st_d.brg = 12'h000;
    end else if (st_q.brg == 12'h000) begin
      tick_t = 1'b1;
      st_d.brg = f_div(st_q.ctrl[3:0]);
    end else begin
      st_d.brg = st_q.brg - 12'h001;
    end
    tick_r = st_q.ctrl[`ASAC_B_RXSRC] ? tick_t : (st_q.s_rc[1] & ~st_q.rc_old);
    st_d.rclk_o = tick_t;

    // reads and program reset first, so hardware sets below win
    st_d.doe = rd;
    if (rd) begin
      case (bus_rs)
        `ASAC_RS_DATA: begin
          st_d.dout = st_q.rdr;
          st_d.rdrf = 1'b0;
          st_d.ovr = 1'b0;
          st_d.echo_rd = 1'b1;
        end
        `ASAC_RS_STAT: begin
          st_d.dout = {st_q.irq, ~st_q.dsr_lv, ~st_q.car_lv, st_q.tdre,
                       st_q.rdrf, st_q.ovr, st_q.fe, st_q.pe};
          st_d.irq = 1'b0;
          st_d.mdm_pend = 1'b0;
        end
        `ASAC_RS_CMD: st_d.dout = st_q.cmd;
        default: st_d.dout = st_q.ctrl;
      endcase
    end
    if (wr && bus_rs == `ASAC_RS_STAT) begin
      st_d.cmd[4:0] = 5'h00;
      st_d.ovr = 1'b0;
    end

    if (!st_q.cmd[0]) begin
      st_d.car_lv = st_q.s_car[1];
      st_d.dsr_lv = st_q.s_dsr[1];
      st_d.mdm_pend = 1'b0;
    end else if (!st_q.mdm_pend &&
                 (st_q.s_car[1] != st_q.car_lv || st_q.s_dsr[1] != st_q.dsr_lv)) begin
      st_d.car_lv = st_q.s_car[1];
      st_d.dsr_lv = st_q.s_dsr[1];
      st_d.mdm_pend = 1'b1;
      ev_mdm = 1'b1;
    end

    // receiver, sampling each bit at its middle
    if (tick_r) begin
      st_d.echo = {st_q.echo[6:0], st_q.s_rx[1]};
      st_d.rx_cnt = st_q.rx_cnt + 5'h01;
    end
    case (st_q.rx)
      rx_idle: begin
        st_d.rx_cnt = 5'h00;
        if (st_q.cmd[0] && !st_q.s_rx[1]) begin
          st_d.rx = rx_start;
          if (st_q.echo_rd) begin
            st_d.echo_blk = 1'b0;
          end
        end
      end
      rx_start: begin
        if (tick_r && st_q.rx_cnt == `ASAC_TICK_MID) begin
          st_d.rx_cnt = 5'h00;
          st_d.rx_bit = 3'h0;
          st_d.rx_sh = 8'h00;
          st_d.rx_pe = 1'b0;
          // a glitch that is high again at mid start is no start bit
          st_d.rx = st_q.s_rx[1] ? rx_idle : rx_data;
        end
      end
      rx_data: begin
        if (tick_r && st_q.rx_cnt == `ASAC_TICK_END) begin
          st_d.rx_cnt = 5'h00;
          st_d.rx_sh[st_q.rx_bit] = st_q.s_rx[1];
          st_d.rx_bit = st_q.rx_bit + 3'h1;
          if ({1'b0, st_q.rx_bit} == nb - 4'h1) begin
            st_d.rx = st_q.cmd[`ASAC_B_PAREN] ? rx_par : rx_stop;
          end
        end
      end
      rx_par: begin
        if (tick_r && st_q.rx_cnt == `ASAC_TICK_END) begin
          st_d.rx_cnt = 5'h00;
          // no check for mark and space
          st_d.rx_pe = !st_q.cmd[7] &&
                       (st_q.s_rx[1] != f_par(st_q.rx_sh, nb, st_q.cmd[7:6]));
          st_d.rx = rx_stop;
        end
      end
      rx_stop: begin
        if (tick_r && st_q.rx_cnt == `ASAC_TICK_END) begin
          st_d.rx_cnt = 5'h00;
          st_d.rx_fe = !st_q.s_rx[1];
          push_w = {st_q.rx_pe, !st_q.s_rx[1], st_q.rx_sh};
          if (stop_end == `ASAC_STOP15) begin
            st_d.rx = rx_tail;
          end else begin
            push = 1'b1;
            st_d.rx = (!st_q.s_rx[1] && st_q.rx_sh == 8'h00) ? rx_brk : rx_idle;
          end
        end
      end
      rx_tail: begin
        if (tick_r && st_q.rx_cnt == `ASAC_TICK_TAIL) begin
          push = 1'b1;
          st_d.rx = rx_idle;
        end
      end
      rx_brk: begin
        if (st_q.s_rx[1]) begin
          st_d.rx = rx_idle;
        end
      end
      default: st_d.rx = rx_idle;
    endcase

    push_v = push & ~st_q.ovr;
    if (push && (!push_rdy || st_q.ovr)) begin
      st_d.ovr = 1'b1;
      st_d.echo_blk = 1'b1;
      st_d.echo_rd = 1'b0;
    end
    pop_rdy = ~st_q.rdrf;
    if (!st_q.rdrf && pop_v) begin
      st_d.rdr = pop_w[7:0];
      st_d.fe = pop_w[8];
      st_d.pe = pop_w[9];
      st_d.rdrf = 1'b1;
      ev_rx = st_q.cmd[0] & ~st_q.cmd[1];
    end

    // transmitter, one bit per sixteen ticks
    if (tick_t) begin
      st_d.tx_cnt = st_q.tx_cnt + 5'h01;
    end
    case (st_q.tx)
      tx_idle: begin
        st_d.tx_cnt = 5'h00;
        if (st_q.cmd[3:2] == `ASAC_TXI_BRK && st_q.tdre) begin
          st_d.tx = tx_brk;
        end else if (!st_q.tdre && st_q.cmd[0] && !echo_on && !(CTS_DEFER && cts_hi)) begin
          st_d.tx = tx_start;
          st_d.tx_sh = st_q.thr;
          st_d.tx_bit = 3'h0;
          st_d.tx_par = f_par(st_q.thr, nb, st_q.cmd[7:6]);
          st_d.tdre = CTS_DEFER || !cts_hi;
          // code 01 interrupts at start bit
          ev_tx = st_q.cmd[3:2] == `ASAC_TXI_ON;
        end
      end
      tx_start: begin
        if (tick_t && st_q.tx_cnt == `ASAC_TICK_END) begin
          st_d.tx_cnt = 5'h00;
          st_d.tx = tx_data;
        end
      end
      tx_data: begin
        if (tick_t && st_q.tx_cnt == `ASAC_TICK_END) begin
          st_d.tx_cnt = 5'h00;
          st_d.tx_sh = {1'b0, st_q.tx_sh[7:1]};
          st_d.tx_bit = st_q.tx_bit + 3'h1;
          if ({1'b0, st_q.tx_bit} == nb - 4'h1) begin
            st_d.tx = st_q.cmd[`ASAC_B_PAREN] ? tx_par : tx_stop;
          end
        end
      end
      tx_par: begin
        if (tick_t && st_q.tx_cnt == `ASAC_TICK_END) begin
          st_d.tx_cnt = 5'h00;
          st_d.tx = tx_stop;
        end
      end
      tx_stop: begin
        if (tick_t && st_q.tx_cnt == stop_end) begin
          st_d.tx = tx_idle;
        end
      end
      tx_brk: begin
        st_d.tx_cnt = 5'h00;
        if (st_q.cmd[3:2] != `ASAC_TXI_BRK) begin
          st_d.tx = tx_stop;
        end
      end
      default: st_d.tx = tx_idle;
    endcase

    // line level follows the next state so the pin and state agree
    case (st_d.tx)
      tx_start: st_d.txd = 1'b0;
      tx_data: st_d.txd = st_d.tx_sh[0];
      tx_par: st_d.txd = st_d.tx_par;
      tx_brk: st_d.txd = 1'b0;
      default: st_d.txd = 1'b1;
    endcase
    if (echo_on) begin
      st_d.txd = st_q.echo_blk | st_q.echo[7];
    end
    if (!CTS_DEFER && cts_hi) begin
      st_d.txd = 1'b1;
    end

    // data, command and control writes last: a load beats the transfer
    if (wr) begin
      case (bus_rs)
        `ASAC_RS_DATA: begin
          st_d.thr = bus_din;
          st_d.tdre = 1'b0;
        end
        `ASAC_RS_CMD: st_d.cmd = bus_din;
        `ASAC_RS_CTRL: st_d.ctrl = bus_din;
        default: st_d.thr = st_q.thr;
      endcase
    end

    ev_any = (ev_rx | ev_tx | ev_mdm) & st_q.cmd[0];
    if (ev_any) begin
      st_d.irq = 1'b1;
    end
    st_d.irq_n = ~st_d.irq;
    st_d.dtr_n = ~st_d.cmd[0];
    st_d.rts_n = (st_d.cmd[3:2] == `ASAC_TXI_OFF) && !st_d.cmd[`ASAC_B_ECHO];
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
      st_q.tdre <= 1'b1;
      st_q.irq_n <= 1'b1;
      st_q.txd <= 1'b1;
      st_q.rts_n <= 1'b1;
      st_q.dtr_n <= 1'b1;
      st_q.s_rx <= 2'h3;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign bus_dout = st_q.dout;
  assign bus_doe = st_q.doe;
  assign irq_n = st_q.irq_n;
  assign txd = st_q.txd;
  assign rts_n = st_q.rts_n;
  assign dtr_n = st_q.dtr_n;
  assign receive_clock_pin_out = st_q.rclk_o;
  assign receive_clock_pin_oe = st_q.ctrl[`ASAC_B_RXSRC];

  property p_irq_set;
    @(posedge mclk) disable iff (!rst_b) ev_any |=> !irq_n && st_q.irq;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("interrupt event did not raise the request");

  property p_irq_clr;
    @(posedge mclk) disable iff (!rst_b)
      (rd && bus_rs == `ASAC_RS_STAT && !ev_any) |=> irq_n;
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("status read did not clear the request");

  property p_err_quiet;
    @(posedge mclk) disable iff (!rst_b)
      (push && !push_rdy && !ev_any && irq_n && !(rd && bus_rs == `ASAC_RS_STAT)) |=>
        st_q.ovr && irq_n;
  endproperty
  a_err_quiet: assert property (p_err_quiet)
    else $error("overrun raised an interrupt");

  property p_ovr;
    @(posedge mclk) disable iff (!rst_b)
      (push && !push_rdy) |=> st_q.ovr && $stable(st_q.rdr);
  endproperty
  a_ovr: assert property (p_ovr)
    else $error("overrun not flagged or data replaced");

  property p_dtr;
    @(posedge mclk) disable iff (!rst_b)
      (wr && bus_rs == `ASAC_RS_CMD) |=> dtr_n == !$past(bus_din[0]);
  endproperty
  a_dtr: assert property (p_dtr)
    else $error("terminal ready does not follow command bit 0");

  property p_rts;
    @(posedge mclk) disable iff (!rst_b)
      (wr && bus_rs == `ASAC_RS_CMD && bus_din[4:2] == 3'h0) ##1 !wr |=> rts_n;
  endproperty
  a_rts: assert property (p_rts)
    else $error("request-to-send not high for code 00");

  property p_prst;
    @(posedge mclk) disable iff (!rst_b)
      (wr && bus_rs == `ASAC_RS_STAT) |=> st_q.cmd[4:0] == 5'h00 && $stable(st_q.ctrl);
  endproperty
  a_prst: assert property (p_prst)
    else $error("program reset left command bits or changed control");

  property p_tdre;
    @(posedge mclk) disable iff (!rst_b)
      (wr && bus_rs == `ASAC_RS_DATA) |=> !st_q.tdre ##1 (st_q.tx != tx_idle || !st_q.tdre);
  endproperty
  a_tdre: assert property (p_tdre)
    else $error("transmit load not registered");

  property p_brk;
    @(posedge mclk) disable iff (!rst_b)
      (st_q.tx == tx_brk && (CTS_DEFER || !$past(st_q.s_cts[1]))) |-> !txd;
  endproperty
  a_brk: assert property (p_brk)
    else $error("break state with line at mark");

  property p_cts;
    @(posedge mclk) disable iff (!rst_b) (!CTS_DEFER && cts_hi) |=> txd;
  endproperty
  a_cts: assert property (p_cts)
    else $error("clear-to-send high did not force mark");
endmodule : asac_core
`default_nettype wire

// File: rtl/asac_fifo.sv
// parameterised first-in first-out buffer held in flip-flops
`timescale 1ns/1ps
`default_nettype none
module asac_fifo #(
  parameter int W = 10,
  parameter int D = 16
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } asac_fifo_s;
  asac_fifo_s st_q, st_d;
  logic wr, rd;

  // full and empty come from the fill count, so both sides see honest flags
  always_comb begin
    st_d = st_q;
    in_ready = (st_q.cnt != (AW+1)'(D));
    out_valid = (st_q.cnt != '0);
    out_data = st_q.mem[st_q.rp];
    wr = in_valid & in_ready;
    rd = out_valid & out_ready;
    if (wr) begin
      st_d.mem[st_q.wp] = in_data;
      st_d.wp = st_q.wp + AW'(1);
    end
    if (rd) begin
      st_d.rp = st_q.rp + AW'(1);
    end
    st_d.cnt = st_q.cnt + (AW+1)'(wr) - (AW+1)'(rd);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule : asac_fifo
`default_nettype wire

// File: rtl/asac_pkg.sv
// state types of the serial core
package asac_pkg;
  typedef enum logic [2:0] {tx_idle, tx_start, tx_data, tx_par, tx_stop, tx_brk} asac_tx_e;
  typedef enum logic [2:0] {rx_idle, rx_start, rx_data, rx_par, rx_stop, rx_tail, rx_brk} asac_rx_e;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] cmd;
    logic [7:0] thr;
    logic tdre;
    logic [7:0] rdr;
    logic rdrf, pe, fe, ovr, irq, irq_n;
    logic car_lv, dsr_lv, mdm_pend;
    logic [7:0] dout;
    logic doe;
    logic [11:0] brg;
    logic [1:0] s_xt, s_rc, s_rx, s_cts, s_car, s_dsr;
    logic xt_old, rc_old;
    asac_tx_e tx;
    logic [4:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_par, txd, rts_n, dtr_n, rclk_o;
    asac_rx_e rx;
    logic [4:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_pe, rx_fe;
    logic [7:0] echo;
    logic echo_blk, echo_rd;
  } asac_state_s;
endpackage : asac_pkg
